// ### eeprom_slave.sv
`timescale 1ns/1ps

// Summary of operation
// - Data changes only while clock is low.
// - Ignore everything until a start marker.
// - Rising data with clock high means stop.
// - Master stops only after data line released.
// - Receiver pulls data low on ninth clock.
// - Acknowledge after address and direction bit.
// - Acknowledge every received write data byte.
// - Read: release, sample ack, continue or quit.
// - Master stops after withholding read acknowledge.
// - Byte write committed by stop, starts write.
// - Busy writing: no response, no acknowledge.
// - Page write up to four bytes, upper page.
// - Write increments two low bits only.
// - Address polling acknowledged only when write done.
// - Direction bit one selects read.
// - Master ends read with nack then stop.
// - Byte read: acknowledge address, send eight bits.
// - Sequential read: next byte per acknowledge.
// - Read address counts all bits, wraps.
// - Array holds 128 bytes of eight bits.
// - Internal write finishes within 10 ms.

module eeprom_slave #(
    parameter int WRITE_CYCLES = eeprom_pkg::WRITE_CYCLES
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    input wire logic clk_en,
    // Two-wire bus
    eeprom_bus_if.device bus,
    // Status
    output logic write_busy
);

    // ********************************************************
    // Declarations
    // ********************************************************
    typedef enum logic [3:0] {
        s_idle, s_addr, s_addr_ack, s_wr, s_wr_ack, s_rd, s_rd_ack, s_ignore, s_busy
    } state_e;
    state_e state_reg;
    logic [2:0] scl_sync_reg, sda_sync_reg;
    logic scl_reg, sda_reg, scl_d_reg, sda_d_reg;
    logic [3:0] cnt_reg;
    logic [6:0] shift_reg;
    logic [eeprom_pkg::ADDR_W-1:0] addr_reg;
    logic rw_reg, ack_on_reg, sda_oe_n_reg;
    logic [eeprom_pkg::PAGE_BYTES-1:0] page_valid_reg;
    logic [eeprom_pkg::DATA_W-1:0] page_data_reg [eeprom_pkg::PAGE_BYTES];
    logic [eeprom_pkg::DATA_W-1:0] mem_reg [eeprom_pkg::MEM_DEPTH];
    logic [eeprom_pkg::TIMER_W-1:0] timer_reg;
    logic scl_rise, scl_fall, start_det, stop_det, commit;
    logic [eeprom_pkg::DATA_W-1:0] rd_byte;

    assign bus.dev_sda_o = 1'b0;
    assign bus.dev_sda_oe_n = sda_oe_n_reg;

    // ********************************************************
    // Pin synchronisers and filter
    // ********************************************************
    // A level counts only once second and third stage agree
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            scl_sync_reg <= 3'h7;
            sda_sync_reg <= 3'h7;
            scl_reg <= 1'b1;
            sda_reg <= 1'b1;
            scl_d_reg <= 1'b1;
            sda_d_reg <= 1'b1;
        end
        else if (clk_en)
        begin
            scl_sync_reg <= {scl_sync_reg[1:0], bus.scl};
            sda_sync_reg <= {sda_sync_reg[1:0], bus.sda};
            if (scl_sync_reg[1] == scl_sync_reg[2])
                scl_reg <= scl_sync_reg[2];
            if (sda_sync_reg[1] == sda_sync_reg[2])
                sda_reg <= sda_sync_reg[2];
            scl_d_reg <= scl_reg;
            sda_d_reg <= sda_reg;
        end
    end

    assign scl_rise = scl_reg && !scl_d_reg;
    assign scl_fall = !scl_reg && scl_d_reg;
    // Data moving while the clock stays high is a marker, never a bit
    assign start_det = scl_reg && scl_d_reg && sda_d_reg && !sda_reg;
    assign stop_det = scl_reg && scl_d_reg && !sda_d_reg && sda_reg;
    assign commit = stop_det && (state_reg == s_wr || state_reg == s_wr_ack)
        && (page_valid_reg != '0);
    assign rd_byte = mem_reg[addr_reg];

    // ********************************************************
    // Protocol state machine
    // ********************************************************
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            state_reg <= s_idle;
            cnt_reg <= eeprom_pkg::BIT_FIRST;
            shift_reg <= 7'h00;
            addr_reg <= eeprom_pkg::ADDR_RESET;
            rw_reg <= eeprom_pkg::RW_WRITE;
            ack_on_reg <= 1'b0;
            sda_oe_n_reg <= 1'b1;
            page_valid_reg <= '0;
            for (int i = 0; i < eeprom_pkg::PAGE_BYTES; i++)
                page_data_reg[i] <= 8'h00;
        end
        else if (clk_en)
        begin
            if (state_reg == s_busy)
            begin
                // Bus inputs are dead until the array write ends
                sda_oe_n_reg <= 1'b1;
                if (timer_reg == '0)
                    state_reg <= s_idle;
            end
            else if (start_det)
            begin
                // A repeated start throws away an unfinished page
                state_reg <= s_addr;
                cnt_reg <= eeprom_pkg::BIT_FIRST;
                ack_on_reg <= 1'b0;
                sda_oe_n_reg <= 1'b1;
                page_valid_reg <= '0;
            end
            else if (stop_det)
            begin
                state_reg <= commit ? s_busy : s_idle;
                sda_oe_n_reg <= 1'b1;
            end
            else
            begin
                case (state_reg)
                    s_idle, s_ignore: sda_oe_n_reg <= 1'b1;
                    s_addr:
                    begin
                        if (scl_rise)
                        begin
                            shift_reg <= {shift_reg[5:0], sda_reg};
                            cnt_reg <= cnt_reg + 4'h1;
                            if (cnt_reg == eeprom_pkg::BIT_LAST)
                            begin
                                addr_reg <= shift_reg;
                                // One reads, zero writes
                                rw_reg <= sda_reg;
                                ack_on_reg <= 1'b0;
                                state_reg <= s_addr_ack;
                            end
                        end
                    end
                    s_addr_ack, s_wr_ack:
                    begin
                        if (scl_fall && !ack_on_reg)
                        begin
                            sda_oe_n_reg <= 1'b0;
                            ack_on_reg <= 1'b1;
                        end
                        else if (scl_fall)
                        begin
                            ack_on_reg <= 1'b0;
                            cnt_reg <= eeprom_pkg::BIT_FIRST;
                            if (state_reg == s_addr_ack && rw_reg == eeprom_pkg::RW_READ)
                            begin
                                state_reg <= s_rd;
                                sda_oe_n_reg <= rd_byte[7];
                            end
                            else
                            begin
                                state_reg <= s_wr;
                                sda_oe_n_reg <= 1'b1;
                            end
                        end
                    end
                    s_wr:
                    begin
                        if (scl_rise)
                        begin
                            shift_reg <= {shift_reg[5:0], sda_reg};
                            cnt_reg <= cnt_reg + 4'h1;
                            if (cnt_reg == eeprom_pkg::BIT_LAST)
                            begin
                                // Only the page offset moves, so extra bytes wrap
                                page_data_reg[addr_reg[1:0]] <= {shift_reg, sda_reg};
                                page_valid_reg[addr_reg[1:0]] <= 1'b1;
                                addr_reg[1:0] <= addr_reg[1:0] + 2'h1;
                                state_reg <= s_wr_ack;
                            end
                        end
                    end
                    s_rd:
                    begin
                        if (scl_rise)
                            cnt_reg <= cnt_reg + 4'h1;
                        else if (scl_fall && cnt_reg == eeprom_pkg::BIT_ACK)
                        begin
                            sda_oe_n_reg <= 1'b1;
                            ack_on_reg <= 1'b0;
                            state_reg <= s_rd_ack;
                        end
                        else if (scl_fall)
                            sda_oe_n_reg <= rd_byte[~cnt_reg[2:0]];
                    end
                    s_rd_ack:
                    begin
                        if (scl_rise && !sda_reg)
                        begin
                            // Full seven-bit count, wraps past the top
                            addr_reg <= addr_reg + 7'h01;
                            ack_on_reg <= 1'b1;
                        end
                        else if (scl_rise)
                            state_reg <= s_ignore;
                        else if (scl_fall && ack_on_reg)
                        begin
                            ack_on_reg <= 1'b0;
                            cnt_reg <= eeprom_pkg::BIT_FIRST;
                            sda_oe_n_reg <= rd_byte[7];
                            state_reg <= s_rd;
                        end
                    end
                    default:
                    begin
                        state_reg <= s_idle;
                        sda_oe_n_reg <= 1'b1;
                    end
                endcase
            end
        end
    end

    // ********************************************************
    // Self-timed write cycle
    // ********************************************************
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            timer_reg <= '0;
            write_busy <= 1'b0;
        end
        else if (clk_en)
        begin
            write_busy <= (state_reg == s_busy);
            if (commit)
                timer_reg <= eeprom_pkg::TIMER_W'(WRITE_CYCLES - 1);
            else if (timer_reg != '0)
                timer_reg <= timer_reg - 1'b1;
        end
    end

    // ********************************************************
    // Storage array
    // ********************************************************
    // Nonvolatile contents, so no reset; all received bytes of the page land at once
    for (genvar e = 0; e < eeprom_pkg::MEM_DEPTH; e++)
    begin : g_mem
        always_ff @(posedge clk)
        begin
            if (clk_en && commit && page_valid_reg[e % eeprom_pkg::PAGE_BYTES]
                && addr_reg[6:2] == 5'(e / eeprom_pkg::PAGE_BYTES))
                mem_reg[e] <= page_data_reg[e % eeprom_pkg::PAGE_BYTES];
        end
    end

endmodule : eeprom_slave

// ### eeprom_pkg.sv
package eeprom_pkg;

    // ********************************************************
    // Array organisation
    // ********************************************************
    localparam int ADDR_W = 7;
    localparam int DATA_W = 8;
    localparam int MEM_DEPTH = 128;
    localparam int PAGE_BYTES = 4;
    localparam int PAGE_W = 2;
    localparam logic [ADDR_W-1:0] ADDR_RESET = 7'h00;
    localparam logic RW_READ = 1'b1;
    localparam logic RW_WRITE = 1'b0;

    // ********************************************************
    // Bit framing
    // ********************************************************
    localparam logic [3:0] BIT_FIRST = 4'h0;
    localparam logic [3:0] BIT_LAST = 4'h7;
    localparam logic [3:0] BIT_ACK = 4'h8;

    // ********************************************************
    // Timing
    // ********************************************************
    localparam int CLK_PERIOD_NS = 8;
    // Longest time, so rounded down
    localparam int WRITE_TIME_MS = 10;
    localparam int WRITE_CYCLES = (WRITE_TIME_MS * 1000000) / CLK_PERIOD_NS;
    localparam int TIMER_W = 21;
    // Least time, so rounded up; four quarters make one serial clock
    localparam int SCL_QUARTER_NS = 2500;
    localparam int QUARTER_CYCLES = (SCL_QUARTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DIV_W = 16;

endpackage : eeprom_pkg

// ### eeprom_bus_if.sv
`timescale 1ns/1ps

interface eeprom_bus_if;
    logic scl;
    logic mst_sda_o;
    logic mst_sda_oe_n;
    logic dev_sda_o;
    logic dev_sda_oe_n;
    logic sda;

    // Open-drain data line with pull-up: any enabled low driver wins
    assign sda = ((!mst_sda_oe_n && !mst_sda_o) || (!dev_sda_oe_n && !dev_sda_o)) ? 1'b0 : 1'b1;

    modport device (
        input scl,
        input sda,
        output dev_sda_o,
        output dev_sda_oe_n
    );

    modport master (
        output scl,
        output mst_sda_o,
        output mst_sda_oe_n,
        input sda
    );
endinterface : eeprom_bus_if

// ### eeprom_master.sv
`timescale 1ns/1ps

module eeprom_master #(
    parameter int QUARTER_CYCLES = eeprom_pkg::QUARTER_CYCLES
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    input wire logic clk_en,
    // Two-wire bus
    eeprom_bus_if.master bus,
    // Command
    input wire logic cmd_valid,
    input wire logic cmd_read,
    input wire logic [6:0] cmd_addr,
    input wire logic [2:0] cmd_count,
    input wire logic [31:0] cmd_wdata,
    output logic cmd_ready,
    // Results
    output logic rd_valid,
    output logic [7:0] rd_data,
    output logic done,
    output logic nack
);

    // ********************************************************
    // Declarations
    // ********************************************************
    typedef enum logic [1:0] {
        m_idle,
        m_start,
        m_bit,
        m_stop
    } state_e;

    state_e state_reg;
    logic [2:0] sda_sync_reg;
    logic sda_reg;
    logic [eeprom_pkg::DIV_W-1:0] div_reg;
    logic [1:0] q_reg;
    logic [3:0] bit_reg;
    logic [2:0] left_reg;
    logic [7:0] tx_reg;
    logic [7:0] rx_reg;
    logic [31:0] wdata_reg;
    logic [1:0] widx_reg;
    logic read_reg;
    logic addr_phase_reg;
    logic scl_reg;
    logic sda_oe_n_reg;
    logic tick;
    logic sending;

    assign bus.scl = scl_reg;
    assign bus.mst_sda_o = 1'b0;
    assign bus.mst_sda_oe_n = sda_oe_n_reg;
    assign tick = (div_reg == '0);
    assign sending = addr_phase_reg || !read_reg;

    // ********************************************************
    // Data line synchroniser
    // ********************************************************
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            sda_sync_reg <= 3'h7;
            sda_reg <= 1'b1;
        end
        else if (clk_en)
        begin
            sda_sync_reg <= {sda_sync_reg[1:0], bus.sda};
            if (sda_sync_reg[1] == sda_sync_reg[2])
                sda_reg <= sda_sync_reg[2];
        end
    end

    // ********************************************************
    // Quarter-period divider
    // ********************************************************
    always_ff @(posedge clk)
    begin
        if (reset)
            div_reg <= '0;
        else if (clk_en)
        begin
            if (state_reg == m_idle || tick)
                div_reg <= eeprom_pkg::DIV_W'(QUARTER_CYCLES - 1);
            else
                div_reg <= div_reg - 1'b1;
        end
    end

    // ********************************************************
    // Sequencer
    // ********************************************************
    // Each bit: clock low, set data, clock high, sample
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            state_reg <= m_idle;
            q_reg <= 2'h0;
            bit_reg <= eeprom_pkg::BIT_FIRST;
            left_reg <= 3'h0;
            tx_reg <= 8'h00;
            rx_reg <= 8'h00;
            wdata_reg <= 32'h00000000;
            widx_reg <= 2'h0;
            read_reg <= 1'b0;
            addr_phase_reg <= 1'b0;
            scl_reg <= 1'b1;
            sda_oe_n_reg <= 1'b1;
            cmd_ready <= 1'b0;
            rd_valid <= 1'b0;
            rd_data <= 8'h00;
            done <= 1'b0;
            nack <= 1'b0;
        end
        else if (clk_en)
        begin
            rd_valid <= 1'b0;
            done <= 1'b0;
            if (state_reg == m_idle)
            begin
                cmd_ready <= 1'b1;
                if (cmd_valid && cmd_ready)
                begin
                    cmd_ready <= 1'b0;
                    state_reg <= m_start;
                    q_reg <= 2'h0;
                    read_reg <= cmd_read;
                    tx_reg <= {cmd_addr, cmd_read};
                    wdata_reg <= cmd_wdata;
                    widx_reg <= 2'h0;
                    left_reg <= (cmd_count == 3'h0) ? 3'h1 : cmd_count;
                    addr_phase_reg <= 1'b1;
                    nack <= 1'b0;
                end
            end
            else if (tick)
            begin
                q_reg <= q_reg + 2'h1;
                case (state_reg)
                    m_start:
                    begin
                        // Data falls while the clock is high
                        if (q_reg == 2'h1)
                            sda_oe_n_reg <= 1'b0;
                        if (q_reg == 2'h3)
                        begin
                            state_reg <= m_bit;
                            bit_reg <= eeprom_pkg::BIT_FIRST;
                        end
                    end
                    m_bit:
                    begin
                        case (q_reg)
                            2'h0: scl_reg <= 1'b0;
                            2'h1:
                            begin
                                if (bit_reg != eeprom_pkg::BIT_ACK)
                                    sda_oe_n_reg <= sending ? tx_reg[7] : 1'b1;
                                else if (sending)
                                    sda_oe_n_reg <= 1'b1;
                                else
                                    sda_oe_n_reg <= (left_reg == 3'h1);
                            end
                            2'h2: scl_reg <= 1'b1;
                            default:
                            begin
                                if (bit_reg != eeprom_pkg::BIT_ACK)
                                begin
                                    tx_reg <= {tx_reg[6:0], 1'b0};
                                    rx_reg <= {rx_reg[6:0], sda_reg};
                                    bit_reg <= bit_reg + 4'h1;
                                end
                                else
                                begin
                                    bit_reg <= eeprom_pkg::BIT_FIRST;
                                    if (sending && sda_reg)
                                    begin
                                        // No answer: device busy or absent
                                        nack <= 1'b1;
                                        state_reg <= m_stop;
                                    end
                                    else if (addr_phase_reg)
                                    begin
                                        addr_phase_reg <= 1'b0;
                                        tx_reg <= wdata_reg[8*widx_reg +: 8];
                                        widx_reg <= widx_reg + 2'h1;
                                    end
                                    else
                                    begin
                                        if (read_reg)
                                        begin
                                            rd_valid <= 1'b1;
                                            rd_data <= rx_reg;
                                        end
                                        left_reg <= left_reg - 3'h1;
                                        tx_reg <= wdata_reg[8*widx_reg +: 8];
                                        widx_reg <= widx_reg + 2'h1;
                                        if (left_reg == 3'h1)
                                            state_reg <= m_stop;
                                    end
                                end
                            end
                        endcase
                    end
                    m_stop:
                    begin
                        // Device has let go by the first low quarter
                        case (q_reg)
                            2'h0: scl_reg <= 1'b0;
                            2'h1: sda_oe_n_reg <= 1'b0;
                            2'h2: scl_reg <= 1'b1;
                            default:
                            begin
                                sda_oe_n_reg <= 1'b1;
                                state_reg <= m_idle;
                                done <= 1'b1;
                            end
                        endcase
                    end
                    default: state_reg <= m_idle;
                endcase
            end
        end
    end

endmodule : eeprom_master

// ### eeprom_checker.sv
`timescale 1ns/1ps
module eeprom_checker (
    // Clock and reset
    input logic clk,
    input logic reset,
    // Bus and status
    input logic scl,
    input logic sda,
    input logic mst_sda_oe_n,
    input logic dev_sda_oe_n,
    input logic write_busy
);
    // ****
    // Bus rules
    // ****
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);
    a_reset_released: assert property ($fell(reset) |-> dev_sda_oe_n && mst_sda_oe_n && scl)
        else $error("line driven right after reset");
    a_busy_silent: assert property (write_busy |-> dev_sda_oe_n)
        else $error("device drives data while busy");
    a_dev_scl_low: assert property ($changed(dev_sda_oe_n) |-> !scl)
        else $error("device changed data with clock high");
    a_drive_held: assert property ($fell(dev_sda_oe_n) |-> !dev_sda_oe_n [*8])
        else $error("device low drive too short");
    a_busy_long: assert property ($rose(write_busy) |-> write_busy [*8])
        else $error("write cycle too short");
    // Bench runs the slave with a 600 cycle write
    a_busy_ends: assert property ($rose(write_busy) |-> ##[590:610] !write_busy)
        else $error("write cycle did not end in time");
    a_busy_on_stop: assert property ($rose(write_busy) |-> scl && sda)
        else $error("write cycle began without a stop");
    a_stop_released: assert property (scl && $past(scl) && $rose(sda) |-> $past(dev_sda_oe_n))
        else $error("stop seen while device drives");
    a_start_released: assert property (scl && $past(scl) && $fell(sda) |-> dev_sda_oe_n)
        else $error("start seen while device drives");
endmodule : eeprom_checker

// ### test_two_wire_eeprom_slave.sv
`timescale 1ns/1ps
module test_two_wire_eeprom_slave;
    typedef struct packed {logic rd; logic [6:0] a; logic [2:0] n; logic [31:0] d;} row_s;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic cmd_valid = 1'b0;
    logic cmd_read = 1'b0;
    logic [6:0] cmd_addr = 7'h00;
    logic [2:0] cmd_count = 3'h1;
    logic [31:0] cmd_wdata = 32'h0;
    logic cmd_ready, rd_valid, done, nack, write_busy;
    logic [7:0] rd_data;
    logic [31:0] rd_buf;
    int rd_cnt;
    int error_cnt = 0;
    int num_checks = 0;
    // Write rows expect no nack; read rows give the bytes, first byte lowest
    row_s rows [7] = '{'{1'b0, 7'h10, 3'h1, 32'hA5}, '{1'b1, 7'h10, 3'h1, 32'hA5},
        '{1'b0, 7'h22, 3'h4, 32'h44332211}, '{1'b1, 7'h20, 3'h4, 32'h22114433},
        '{1'b0, 7'h7E, 3'h2, 32'h6655}, '{1'b0, 7'h00, 3'h1, 32'h77}, '{1'b1, 7'h7F, 3'h2, 32'h7766}};
    eeprom_bus_if bus_if ();
    eeprom_slave #(.WRITE_CYCLES(600)) u_eeprom_slave (.clk(clk), .reset(reset), .clk_en(1'b1),
        .bus(bus_if), .write_busy(write_busy));
    eeprom_master #(.QUARTER_CYCLES(8)) u_eeprom_master (.clk(clk), .reset(reset), .clk_en(1'b1),
        .bus(bus_if), .cmd_valid(cmd_valid), .cmd_read(cmd_read), .cmd_addr(cmd_addr),
        .cmd_count(cmd_count), .cmd_wdata(cmd_wdata), .cmd_ready(cmd_ready),
        .rd_valid(rd_valid), .rd_data(rd_data), .done(done), .nack(nack));
    eeprom_checker u_eeprom_checker (.clk(clk), .reset(reset), .scl(bus_if.scl), .sda(bus_if.sda),
        .mst_sda_oe_n(bus_if.mst_sda_oe_n), .dev_sda_oe_n(bus_if.dev_sda_oe_n),
        .write_busy(write_busy));
    always #4 clk = ~clk;
    always @(negedge clk)
        if (rd_valid === 1'b1)
        begin
            rd_buf[rd_cnt[1:0]*8 +: 8] = rd_data;
            rd_cnt++;
        end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic run(input row_s r);
        do @(negedge clk); while (cmd_ready !== 1'b1);
        rd_cnt = 0;
        rd_buf = 32'h0;
        @(posedge clk);
        cmd_valid <= 1'b1;
        cmd_read <= r.rd;
        cmd_addr <= r.a;
        cmd_count <= r.n;
        cmd_wdata <= r.d;
        @(posedge clk);
        cmd_valid <= 1'b0;
        do @(negedge clk); while (done !== 1'b1);
    endtask : run
    // Busy rises a few cycles after the stop, so give it time to appear
    task automatic wait_idle;
        repeat (20) @(negedge clk);
        while (write_busy === 1'b1) @(negedge clk);
    endtask : wait_idle
    task automatic final_report;
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : final_report
    initial
    begin
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        foreach (rows[i])
        begin
            run(rows[i]);
            check(nack, 1'b0);
            if (rows[i].rd)
                check(rd_buf, rows[i].d);
            else
                wait_idle();
            $display("row %0d done", i);
        end
        // Busy outlasts the poll's address slot, so the poll must be refused
        run(row_s'{1'b0, 7'h40, 3'h1, 32'h5A});
        run(row_s'{1'b1, 7'h40, 3'h1, 32'h0});
        check(nack, 1'b1);
        wait_idle();
        run(row_s'{1'b1, 7'h40, 3'h1, 32'h0});
        check(rd_buf, 32'h5A);
        $display("poll test done");
        @(posedge clk);
        reset <= 1'b1;
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        @(negedge clk);
        check(write_busy, 1'b0);
        check(bus_if.dev_sda_oe_n, 1'b1);
        run(rows[1]);
        check(rd_buf, 32'hA5);
        $display("reset test done");
        final_report();
    end
    initial
    begin
        #(60000 * 8);
        error_cnt++;
        $display("watchdog expired");
        final_report();
    end
endmodule : test_two_wire_eeprom_slave
